// ### acs_pkg.sv
// types and constants for the converter glue
package acs_pkg;

    // register byte offsets
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_START  = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_MASK   = 8'h0C;
    localparam logic [7:0] ADDR_RESULT = 8'h10;
    localparam logic [7:0] ADDR_INFO   = 8'h14;

    // field positions
    localparam int CTRL_W        = 21;
    localparam int START_BIT     = 0;
    localparam int ST_DONE       = 0;
    localparam int ST_REFUSED    = 1;
    localparam int ST_CLK_SUBST  = 2;
    localparam int ST_W          = 3;
    localparam int INFO_CLK_LSB  = 0;
    localparam int INFO_MODE_LSB = 4;
    localparam int INFO_CHIP_LSB = 8;

    // reset values
    localparam logic [CTRL_W-1:0] CTRL_RST = 21'h00001F;
    localparam logic [ST_W-1:0]   MASK_RST = 3'h0;

    // channel codes
    localparam logic [4:0] CH_PAIR_LAST = 5'h03;
    localparam logic [4:0] CH_DM0       = 5'h13;
    localparam logic [4:0] CH_DM1       = 5'h14;
    localparam logic [4:0] CH_DAC       = 5'h17;
    localparam logic [4:0] CH_TEMP      = 5'h1A;
    localparam logic [4:0] CH_BANDGAP   = 5'h1B;
    localparam logic [4:0] CH_HIGH_REFERENCE_INPUT     = 5'h1D;
    localparam logic [4:0] CH_LOW_REFERENCE_INPUT     = 5'h1E;
    localparam logic [4:0] CH_DISABLE   = 5'h1F;

    // conversion clock select codes
    localparam logic [1:0] CLK_BUS   = 2'h0;
    localparam logic [1:0] CLK_RC48  = 2'h1;
    localparam logic [1:0] CLK_OSC   = 2'h2;
    localparam logic [1:0] CLK_ASYNC = 2'h3;

    typedef enum logic [3:0] {
        CHIP_RUN, CHIP_WAIT, CHIP_STOP, CHIP_VLPR, CHIP_VERY_LOW_POWER_WAIT, CHIP_VERY_LOW_POWER_STOP,
        CHIP_LLS, CHIP_VERY_LOW_LEAKAGE_STOP_3, CHIP_VLLS2, CHIP_VLLS1, CHIP_VLLS0,
        CHIP_COMPUTE, CHIP_PARTIAL_STOP_1
    } acs_chip_mode_t;

    typedef enum logic [1:0] {CM_RUN, CM_WAIT, CM_NSTOP, CM_LPSTOP} acs_conv_mode_t;

    typedef enum logic [3:0] {
        SRC_NONE, SRC_PAIR, SRC_PIN_P, SRC_PIN_M, SRC_SE_A, SRC_SE_B, SRC_DAC,
        SRC_TEMP, SRC_BANDGAP, SRC_HIGH_REFERENCE_INPUT, SRC_LOW_REFERENCE_INPUT, SRC_OFF
    } acs_src_kind_t;

    typedef struct packed {
        acs_src_kind_t kind;
        logic [4:0]    index;
        logic          neg_en;
    } acs_sel_t;

    typedef struct packed {
        logic       dma_en;
        logic [3:0] pdb_in_sel;
        logic       hw_trig_en;
        logic       alt_trig_en;
        logic [3:0] alt_trigger_source_select;
        logic [1:0] conversion_clock_select;
        logic       reference_source_select;
        logic       alt_input_set_select;
        logic       diff;
        logic [4:0] conversion_channel_code;
    } acs_ctrl_t;

    typedef struct packed {
        logic       ext_pin;
        logic [1:0] analog_comparator;
        logic [3:0] periodic_interval_timer;
        logic [2:0] flexible_timer;
        logic       low_power_timer;
    } acs_trig_src_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } acs_bus_req_t;

    // trigger level for a source code, reserved give 0
    function automatic logic trig_pick(input acs_trig_src_t s, input logic [3:0] code);
        logic r;
        r = 1'b0;
        case (code)
            4'h0: r = s.ext_pin;
            4'h1: r = s.analog_comparator[0];
            4'h2: r = s.analog_comparator[1];
            4'h4, 4'h5, 4'h6, 4'h7: r = s.periodic_interval_timer[code[1:0]];
            4'h8: r = s.flexible_timer[0];
            4'h9: r = s.flexible_timer[1];
            4'hA: r = s.flexible_timer[2];
            4'hE: r = s.low_power_timer;
            default: r = 1'b0;
        endcase
        return r;
    endfunction : trig_pick

    // modes limited to async and alternate clocks
    function automatic logic clk_restricted(input acs_chip_mode_t m);
        return (m == CHIP_COMPUTE) || (m == CHIP_PARTIAL_STOP_1) || (m == CHIP_STOP) ||
               (m == CHIP_VERY_LOW_POWER_STOP);
    endfunction : clk_restricted

endpackage : acs_pkg

// ### acs_trig_select.sv
// trigger source multiplexer with rising-edge detection
`timescale 1ns/100ps
`default_nettype none
module acs_trig_select
    import acs_pkg::*;
(
    input  wire logic               ref_clk,
    input  wire logic               reset,
    input  wire logic               clk_en,
    input  wire acs_pkg::acs_trig_src_t src,
    input  wire logic [3:0]         sel,
    output logic                    pulse
);
    logic level_reg;
    logic level_next;

    always_comb
    begin
        level_next = trig_pick(src, sel);
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            level_reg <= 1'b0;
        else if (clk_en)
            level_reg <= level_next;
    end

    // a change of source code can fake one edge; accepted
    assign pulse = clk_en & level_next & ~level_reg;
endmodule : acs_trig_select
`default_nettype wire

// ### acs_chan_decode.sv
// channel code and differential flag to converter input selection
`timescale 1ns/100ps
`default_nettype none
module acs_chan_decode
    import acs_pkg::*;
(
    input  wire logic [4:0]  chan,
    input  wire logic        diff,
    input  wire logic        set_b,
    output acs_pkg::acs_sel_t sel
);
    always_comb
    begin
        sel = '{kind: SRC_NONE, index: chan, neg_en: 1'b0};
        if (chan == CH_DISABLE)
            sel.kind = SRC_OFF;
        else if (chan <= CH_PAIR_LAST)
        begin
            sel.kind   = diff ? SRC_PAIR : SRC_PIN_P;
            sel.neg_en = diff;
        end
        else if (diff)
        begin
            case (chan)
                CH_TEMP:    sel.kind = SRC_TEMP;
                CH_BANDGAP: sel.kind = SRC_BANDGAP;
                CH_HIGH_REFERENCE_INPUT:   sel.kind = SRC_HIGH_REFERENCE_INPUT;
                default:    sel.kind = SRC_NONE;
            endcase
        end
        else
        begin
            case (chan)
                5'h04, 5'h05, 5'h06, 5'h07:
                    sel.kind = set_b ? SRC_SE_B : SRC_SE_A;
                5'h08, 5'h09, 5'h0C, 5'h0D, 5'h0E, 5'h0F, 5'h11, 5'h12:
                    sel.kind = SRC_PIN_P;
                CH_DM0:
                begin
                    sel.kind  = SRC_PIN_M;
                    sel.index = 5'h00;
                end
                CH_DM1:
                begin
                    sel.kind  = SRC_PIN_M;
                    sel.index = 5'h01;
                end
                CH_DAC:     sel.kind = SRC_DAC;
                CH_TEMP:    sel.kind = SRC_TEMP;
                CH_BANDGAP: sel.kind = SRC_BANDGAP;
                CH_HIGH_REFERENCE_INPUT:   sel.kind = SRC_HIGH_REFERENCE_INPUT;
                CH_LOW_REFERENCE_INPUT:   sel.kind = SRC_LOW_REFERENCE_INPUT;
                default:    sel.kind = SRC_NONE;
            endcase
        end
    end
endmodule : acs_chan_decode
`default_nettype wire

// ### acs_top.sv
// converter glue top: input, trigger, clock and power-mode selection
// Overview of operation
// - differential pairs or positive input, codes 0-3
// - single-ended codes 4-7 pick set a or b
// - code 31 disables the converter
// - reference select picks primary or 1.2 V
// - software and hardware starts, delay block default
// - alternate trigger select bypasses the delay block
// - low-power conversions, result stored, waking interrupt
// - two-bit select picks one of four clocks
// - restricted clocks in stop-like and compute modes, RC off only in very-low-power stop
// - chip low-power modes map onto converter modes
// - delay block input accepts low-power timer
// - conversion completion can request DMA
//
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module acs_top
    import acs_pkg::*;
(
    input  wire logic                    ref_clk,
    input  wire logic                    reset,
    input  wire logic                    clk_en,
    input  wire logic [7:0]              reg_addr,
    input  wire logic [31:0]             reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output logic [31:0]                  reg_rdata,
    input  wire acs_pkg::acs_trig_src_t  trig_src,
    input  wire logic                    pdb_adc_trig,
    input  wire acs_pkg::acs_chip_mode_t chip_mode,
    input  wire logic                    bandgap_buffer_enable,
    input  wire logic                    conv_done,
    input  wire logic [15:0]             conv_result,
    output acs_pkg::acs_sel_t            input_sel,
    output logic                         conv_enable,
    output logic                         ref_use_alt,
    output logic [1:0]                   conv_clk_sel,
    output acs_pkg::acs_conv_mode_t      conv_mode,
    output logic                         conv_start,
    output logic                         pdb_in_trig,
    output logic                         dma_req,
    output logic                         irq,
    output logic                         wake_req
);
    typedef enum logic {FSM_IDLE, FSM_BUSY} acs_fsm_t;

    typedef struct packed {
        acs_ctrl_t       ctrl;
        logic [ST_W-1:0] status;
        logic [ST_W-1:0] mask;
        logic [15:0]     result;
        logic [31:0]     rdata;
        acs_fsm_t        fsm;
        acs_sel_t        sel;
        logic            conv_en;
        logic            ref_alt;
        logic [1:0]      clk_sel;
        acs_conv_mode_t  mode;
        logic            start;
        logic            pdb_in;
        logic            dma;
        logic            irq;
        logic            wake;
    } acs_state_t;

    acs_state_t state_reg;
    acs_state_t state_next;
    acs_sel_t   dec_sel;
    logic       alt_pulse;
    logic       pdb_in_pulse;
    logic       pdb_edge_reg;
    logic       hw_trig;
    logic       sw_start;
    logic       start_req;
    logic       start_ok;
    logic       done_evt;
    logic       refuse_evt;
    logic       subst_evt;
    logic [1:0] clk_pick;
    logic       lp_mode;
    acs_conv_mode_t mode_pick;

    acs_chan_decode u_decode (
        .chan  (state_reg.ctrl.conversion_channel_code),
        .diff  (state_reg.ctrl.diff),
        .set_b (state_reg.ctrl.alt_input_set_select),
        .sel   (dec_sel)
    );

    acs_trig_select u_alt_trig (
        .ref_clk (ref_clk),
        .reset   (reset),
        .clk_en  (clk_en),
        .src     (trig_src),
        .sel     (state_reg.ctrl.alt_trigger_source_select),
        .pulse   (alt_pulse)
    );

    // delay block input trigger, same source map
    acs_trig_select u_pdb_in (
        .ref_clk (ref_clk),
        .reset   (reset),
        .clk_en  (clk_en),
        .src     (trig_src),
        .sel     (state_reg.ctrl.pdb_in_sel),
        .pulse   (pdb_in_pulse)
    );

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            pdb_edge_reg <= 1'b0;
        else if (clk_en)
            pdb_edge_reg <= pdb_adc_trig;
    end

    always_comb
    begin
        // chip to converter power mode
        case (chip_mode)
            CHIP_WAIT, CHIP_VERY_LOW_POWER_WAIT:   mode_pick = CM_WAIT;
            CHIP_STOP, CHIP_VERY_LOW_POWER_STOP:   mode_pick = CM_NSTOP;
            CHIP_LLS, CHIP_VERY_LOW_LEAKAGE_STOP_3, CHIP_VLLS2, CHIP_VLLS1, CHIP_VLLS0:
                                    mode_pick = CM_LPSTOP;
            default:                mode_pick = CM_RUN;
        endcase
        lp_mode = (mode_pick != CM_RUN) || clk_restricted(chip_mode);

        // async clock stands in for one that is off in this mode
        clk_pick  = state_reg.ctrl.conversion_clock_select;
        subst_evt = 1'b0;
        if (clk_restricted(chip_mode) && clk_pick == CLK_BUS)
        begin
            clk_pick  = CLK_ASYNC;
            subst_evt = 1'b1;
        end
        else if (chip_mode == CHIP_VERY_LOW_POWER_STOP && clk_pick == CLK_RC48)
        begin
            clk_pick  = CLK_ASYNC;
            subst_evt = 1'b1;
        end
        subst_evt = subst_evt && state_reg.start;

        // delay block idles in low-power modes
        if (state_reg.ctrl.alt_trig_en)
            hw_trig = alt_pulse;
        else
            hw_trig = pdb_adc_trig && !pdb_edge_reg && !lp_mode;
        hw_trig  = hw_trig && state_reg.ctrl.hw_trig_en;
        sw_start = reg_wr && reg_addr == ADDR_START && reg_wdata[START_BIT];
        start_req = (sw_start || hw_trig) && state_reg.fsm == FSM_IDLE;
        // reserved codes and unbuffered bandgap refused
        start_ok = dec_sel.kind != SRC_NONE && dec_sel.kind != SRC_OFF &&
                   !(dec_sel.kind == SRC_BANDGAP && !bandgap_buffer_enable);
        refuse_evt = start_req && !start_ok;
        done_evt   = conv_done && state_reg.fsm == FSM_BUSY;

        state_next       = state_reg;
        state_next.start = 1'b0;
        state_next.dma   = 1'b0;
        state_next.rdata = 32'h00000000;
        state_next.sel   = dec_sel;
        state_next.conv_en = dec_sel.kind != SRC_OFF;
        state_next.ref_alt = state_reg.ctrl.reference_source_select;
        state_next.clk_sel = clk_pick;
        state_next.mode    = mode_pick;
        state_next.pdb_in  = pdb_in_pulse;

        if (reg_wr)
        begin
            case (reg_addr)
                ADDR_CTRL: state_next.ctrl = acs_ctrl_t'(reg_wdata[CTRL_W-1:0]);
                ADDR_MASK: state_next.mask = reg_wdata[ST_W-1:0];
                default:   ;
            endcase
        end

        if (reg_rd)
        begin
            case (reg_addr)
                ADDR_CTRL:   state_next.rdata = {11'h000, state_reg.ctrl};
                ADDR_STATUS:
                begin
                    state_next.rdata  = {29'h00000000, state_reg.status};
                    state_next.status = 3'h0;
                end
                ADDR_MASK:   state_next.rdata = {29'h00000000, state_reg.mask};
                ADDR_RESULT: state_next.rdata = {16'h0000, state_reg.result};
                ADDR_INFO:
                begin
                    state_next.rdata[INFO_CLK_LSB +: 2]  = state_reg.clk_sel;
                    state_next.rdata[INFO_MODE_LSB +: 2] = state_reg.mode;
                    state_next.rdata[INFO_CHIP_LSB +: 4] = chip_mode;
                    state_next.rdata[12]                 = state_reg.fsm == FSM_BUSY;
                end
                default:     state_next.rdata = 32'h00000000;
            endcase
        end

        case (state_reg.fsm)
            FSM_IDLE:
            begin
                if (start_req && start_ok)
                begin
                    state_next.start = 1'b1;
                    state_next.fsm   = FSM_BUSY;
                end
            end
            FSM_BUSY:
            begin
                if (done_evt)
                begin
                    state_next.result = conv_result;
                    state_next.dma    = state_reg.ctrl.dma_en;
                    state_next.fsm    = FSM_IDLE;
                end
            end
            default: state_next.fsm = FSM_IDLE;
        endcase

        // event beats a clearing read
        state_next.status[ST_DONE]      = state_next.status[ST_DONE] | done_evt;
        state_next.status[ST_REFUSED]   = state_next.status[ST_REFUSED] | refuse_evt;
        state_next.status[ST_CLK_SUBST] = state_next.status[ST_CLK_SUBST] | subst_evt;
        state_next.irq  = |(state_next.status & state_next.mask);
        state_next.wake = state_next.irq && lp_mode;
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            state_reg         <= '0;
            state_reg.ctrl    <= acs_ctrl_t'(CTRL_RST);
            state_reg.mask    <= MASK_RST;
            state_reg.fsm     <= FSM_IDLE;
            state_reg.sel     <= '{kind: SRC_OFF, index: 5'h1F, neg_en: 1'b0};
            state_reg.mode    <= CM_RUN;
        end
        else if (clk_en)
            state_reg <= state_next;
    end

    assign reg_rdata    = state_reg.rdata;
    assign input_sel    = state_reg.sel;
    assign conv_enable  = state_reg.conv_en;
    assign ref_use_alt  = state_reg.ref_alt;
    assign conv_clk_sel = state_reg.clk_sel;
    assign conv_mode    = state_reg.mode;
    assign conv_start   = state_reg.start;
    assign pdb_in_trig  = state_reg.pdb_in;
    assign dma_req      = state_reg.dma;
    assign irq          = state_reg.irq;
    assign wake_req     = state_reg.wake;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset || !clk_en);

    chk_pair_route: assert property (
        input_sel.kind == SRC_PAIR |-> $past(state_reg.ctrl.diff) &&
            $past(state_reg.ctrl.conversion_channel_code) <= CH_PAIR_LAST && input_sel.neg_en)
        else $error("pair routed for wrong code or flag");
    chk_alt_set: assert property (
        !state_reg.ctrl.diff && state_reg.ctrl.conversion_channel_code inside {[4:7]}
        |=> input_sel.kind == ($past(state_reg.ctrl.alt_input_set_select) ? SRC_SE_B : SRC_SE_A))
        else $error("alternate input set not followed");
    chk_disable_code: assert property (
        state_reg.ctrl.conversion_channel_code == CH_DISABLE |=> !conv_enable)
        else $error("converter enabled on disable code");
    chk_bandgap_gate: assert property (
        start_req && dec_sel.kind == SRC_BANDGAP && !bandgap_buffer_enable
        |=> !conv_start && state_reg.status[ST_REFUSED])
        else $error("bandgap start without buffer");
    chk_ref_follow: assert property (
        ##1 ref_use_alt == $past(state_reg.ctrl.reference_source_select))
        else $error("reference select not followed");
    chk_start_once: assert property (
        conv_start |-> state_reg.fsm == FSM_BUSY ##1 !conv_start)
        else $error("start pulse longer than one cycle");
    chk_done_irq: assert property (
        done_evt && state_reg.mask[ST_DONE] |=> irq && state_reg.status[ST_DONE])
        else $error("completion did not interrupt");
    chk_clk_legal: assert property (
        clk_restricted(chip_mode) |=> conv_clk_sel != CLK_BUS)
        else $error("bus clock used in restricted mode");
    chk_very_low_power_stop_rc: assert property (
        chip_mode == CHIP_VERY_LOW_POWER_STOP |=> conv_clk_sel != CLK_RC48 && conv_mode == CM_NSTOP)
        else $error("RC clock or mode wrong");
    chk_lls_mode: assert property (
        chip_mode inside {CHIP_LLS, CHIP_VLLS0} |=> conv_mode == CM_LPSTOP)
        else $error("low-leakage stop not mapped");
    chk_dma_pulse: assert property (
        done_evt && state_reg.ctrl.dma_en |=> dma_req ##1 !dma_req)
        else $error("dma request not a single pulse");

    cov_conversion: cover property (conv_start ##[1:20] dma_req);
    cov_alt_trigger: cover property (state_reg.ctrl.alt_trig_en && alt_pulse ##1 conv_start);
    cov_lp_wake: cover property (lp_mode && done_evt ##1 wake_req);
    cov_refused: cover property (refuse_evt);
endmodule : acs_top
`default_nettype wire

// ### acs_partner.sv
// trigger sources, delay block and converter core stand-in
`timescale 1ns/100ps
`default_nettype none
module acs_partner
    import acs_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              reset,
    input  wire logic              fire,
    input  wire logic [3:0]        fire_code,
    input  wire logic              conv_start,
    output acs_pkg::acs_trig_src_t trig_src,
    output logic                   pdb_adc_trig,
    output logic                   conv_done,
    output logic [15:0]            conv_result
);
    logic [1:0] hold_reg;
    logic [3:0] lat_reg;
    logic [7:0] cnt_reg;
    // result inverts off done to expose stale capture
    assign conv_result = conv_done ? {8'h5A, cnt_reg} : ~{8'h5A, cnt_reg};
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            trig_src <= '0;
            pdb_adc_trig <= 1'b0;
            hold_reg <= 2'h0;
            lat_reg <= 4'h0;
            cnt_reg <= 8'h00;
            conv_done <= 1'b0;
        end
        else
        begin
            conv_done <= 1'b0;
            if (fire)
            begin
                hold_reg <= 2'h3;
                pdb_adc_trig <= (fire_code == 4'hF);
                case (fire_code)
                    4'h0: trig_src <= 11'h400;
                    4'h1, 4'h2: trig_src <= 11'h080 << fire_code;
                    4'h4, 4'h5, 4'h6, 4'h7: trig_src <= 11'h010 << fire_code[1:0];
                    4'h8, 4'h9, 4'hA: trig_src <= 11'h002 << fire_code[1:0];
                    4'hE: trig_src <= 11'h001;
                    4'hF: trig_src <= '0;
                    // reserved code: every source rises at once
                    default: trig_src <= 11'h7FF;
                endcase
            end
            else if (hold_reg != 2'h0)
            begin
                hold_reg <= hold_reg - 2'h1;
                if (hold_reg == 2'h1)
                begin
                    trig_src <= '0;
                    pdb_adc_trig <= 1'b0;
                end
            end
            if (conv_start)
            begin
                cnt_reg <= cnt_reg + 8'h01;
                // latency 3 to 6 cycles
                lat_reg <= 4'h3 + {2'h0, cnt_reg[1:0]};
            end
            else if (lat_reg != 4'h0)
            begin
                lat_reg <= lat_reg - 4'h1;
                conv_done <= (lat_reg == 4'h1);
            end
        end
    end
endmodule : acs_partner
`default_nettype wire

// ### tb_adc_channel_trigger_clock_select.sv
// self-checking bench for the converter glue
`timescale 1ns/100ps
`default_nettype none
module tb_adc_channel_trigger_clock_select;
    import acs_pkg::*;
    logic ref_clk, reset, reg_wr, reg_rd, fire, bandgap_buffer_enable, pdb_adc_trig, conv_done;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rv;
    logic [3:0] fire_code;
    logic [15:0] conv_result;
    logic [1:0] conv_clk_sel;
    logic conv_enable, ref_use_alt, conv_start, pdb_in_trig, dma_req, irq, wake_req;
    acs_chip_mode_t chip_mode;
    acs_trig_src_t trig_src;
    acs_sel_t input_sel, es;
    acs_conv_mode_t conv_mode;
    acs_ctrl_t c;
    logic [3:0] tc [12] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hE, 4'h3};
    int bad_count, cmp_count, cyc, n_start, n_pdb, n_dma, n_wake, b0, w0, k, seed;
    acs_top uut (.ref_clk, .reset, .clk_en(1'b1), .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .trig_src, .pdb_adc_trig, .chip_mode, .bandgap_buffer_enable, .conv_done,
        .conv_result, .input_sel, .conv_enable, .ref_use_alt, .conv_clk_sel, .conv_mode,
        .conv_start, .pdb_in_trig, .dma_req, .irq, .wake_req);
    acs_partner far (.ref_clk, .reset, .fire, .fire_code, .conv_start, .trig_src,
        .pdb_adc_trig, .conv_done, .conv_result);
    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    task automatic close_out();
        $display("checks %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : close_out
    always @(posedge ref_clk)
    begin
        cyc++;
        n_start += int'(conv_start);
        n_pdb += int'(pdb_in_trig);
        n_dma += int'(dma_req);
        n_wake += int'(wake_req);
        if (cyc == 6000)
        begin
            bad_count++;
            close_out();
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, got);
        cmp_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd
    task automatic setc(input acs_chip_mode_t m);
        @(posedge ref_clk);
        chip_mode <= m;
        wr(ADDR_CTRL, {11'h0, c});
        repeat (3) @(posedge ref_clk);
        #1;
    endtask : setc
    task automatic kick(input logic [3:0] f);
        @(posedge ref_clk);
        fire <= 1'b1;
        fire_code <= f;
        @(posedge ref_clk);
        fire <= 1'b0;
        repeat (20) @(posedge ref_clk);
    endtask : kick
    function automatic acs_sel_t esel(input logic [4:0] ch, input logic d, input logic b);
        acs_sel_t s;
        s.index = ch;
        s.neg_en = d && ch <= CH_PAIR_LAST;
        if (ch == CH_DISABLE) s.kind = SRC_OFF;
        else if (ch <= CH_PAIR_LAST) s.kind = d ? SRC_PAIR : SRC_PIN_P;
        else if (d) s.kind = SRC_NONE;
        else s.kind = b ? SRC_SE_B : SRC_SE_A;
        return s;
    endfunction : esel
    function automatic logic [1:0] eclk(input logic [1:0] s, input acs_chip_mode_t m);
        logic r;
        r = m inside {CHIP_COMPUTE, CHIP_PARTIAL_STOP_1, CHIP_STOP, CHIP_VERY_LOW_POWER_STOP};
        return ((r && s == CLK_BUS) || (m == CHIP_VERY_LOW_POWER_STOP && s == CLK_RC48)) ? CLK_ASYNC : s;
    endfunction : eclk
    function automatic acs_conv_mode_t emode(input acs_chip_mode_t m);
        if (m inside {CHIP_WAIT, CHIP_VERY_LOW_POWER_WAIT}) return CM_WAIT;
        if (m inside {CHIP_STOP, CHIP_VERY_LOW_POWER_STOP}) return CM_NSTOP;
        if (m >= CHIP_LLS && m <= CHIP_VLLS0) return CM_LPSTOP;
        return CM_RUN;
    endfunction : emode
    initial
    begin
        seed = 13860;
        {reset, reg_wr, reg_rd, fire, bandgap_buffer_enable} = 5'h10;
        {reg_addr, reg_wdata, fire_code} = '0;
        chip_mode = CHIP_RUN;
        repeat (16) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        #1;
        chk("reset kind", SRC_OFF, input_sel.kind);
        rd(ADDR_CTRL, rv);
        chk("ctrl reset", CTRL_RST, rv);
        for (int i = 0; i < 40; i++)
        begin
            k = $unsigned($random(seed)) % 9;
            c = '0;
            c.conversion_channel_code = (k == 8) ? CH_DISABLE : 5'(k);
            {c.diff, c.alt_input_set_select, c.reference_source_select} = 3'($random(seed));
            c.conversion_clock_select = 2'($random(seed));
            setc(acs_chip_mode_t'(4'($unsigned($random(seed)) % 13)));
            es = esel(c.conversion_channel_code, c.diff, c.alt_input_set_select);
            chk("kind", es.kind, input_sel.kind);
            if (es.kind != SRC_NONE) chk("sel", es, input_sel);
            chk("enable", k != 8, conv_enable);
            chk("ref", c.reference_source_select, ref_use_alt);
            chk("clk", eclk(c.conversion_clock_select, chip_mode), conv_clk_sel);
            chk("mode", emode(chip_mode), conv_mode);
        end
        $display("test decode done");
        c = '0;
        c.dma_en = 1'b1;
        setc(CHIP_RUN);
        wr(ADDR_MASK, 32'h1);
        {b0, w0} = {n_start, n_dma};
        wr(ADDR_START, 32'h1);
        repeat (20) @(posedge ref_clk);
        #1;
        chk("sw start", 1, n_start - b0);
        chk("dma", 1, n_dma - w0);
        chk("irq", 1, irq);
        rd(ADDR_RESULT, rv);
        chk("result", {16'h0, 8'h5A, n_start[7:0]}, rv);
        rd(ADDR_STATUS, rv);
        chk("status", 1, rv);
        @(posedge ref_clk);
        #1;
        chk("irq clear", 0, irq);
        rd(8'h20, rv);
        chk("unmapped", 0, rv);
        $display("test sw start done");
        {c.hw_trig_en, c.alt_trig_en} = 2'h3;
        foreach (tc[j])
        begin
            c.alt_trigger_source_select = tc[j];
            setc(CHIP_VERY_LOW_POWER_WAIT);
            {b0, w0} = {n_start, n_wake};
            kick(tc[j]);
            chk("alt start", tc[j] != 4'h3, n_start - b0);
            chk("wake", tc[j] != 4'h3, n_wake > w0);
            rd(ADDR_STATUS, rv);
        end
        c.alt_trig_en = 1'b0;
        setc(CHIP_RUN);
        b0 = n_start;
        kick(4'hF);
        chk("delay start", 1, n_start - b0);
        c = '0;
        c.pdb_in_sel = 4'hE;
        setc(CHIP_RUN);
        b0 = n_pdb;
        kick(4'hE);
        chk("pdb input", 1, n_pdb - b0);
        $display("test triggers done");
        c = '0;
        c.conversion_channel_code = CH_BANDGAP;
        setc(CHIP_RUN);
        b0 = n_start;
        wr(ADDR_START, 32'h1);
        repeat (20) @(posedge ref_clk);
        bandgap_buffer_enable <= 1'b1;
        rd(ADDR_STATUS, rv);
        chk("refused", 32'h2, rv & 32'h2);
        wr(ADDR_START, 32'h1);
        repeat (20) @(posedge ref_clk);
        chk("bandgap", 1, n_start - b0);
        $display("test bandgap done");
        close_out();
    end
endmodule : tb_adc_channel_trigger_clock_select
`default_nettype wire
